//--- core/button_if.sv
// Purpose: carries the cleaned reset button level to the supervisor
// Assumes: one clock domain
// Notes: valid rises once the first settled level is known
interface button_if;
  logic level;
  logic valid;
  modport source (output level, output valid);
  modport sink (input level, input valid);
endinterface

//--- core/reset_debounce.sv
// Purpose: synchroniser and debouncer for the reset button input
// Assumes: input is high when released (pad pull-up), low when pressed
// Notes: output is held released until the first settled sample
`include "status_led_cfg.svh"
module reset_debounce #(
  parameter int unsigned SETTLE_CYCLES = `DEBOUNCE_TIME_MS * `CYC_PER_MS
) (
  input wire logic clk_sys,     // system clock
  input wire logic reset_n,     // synchronous reset, active low
  input wire logic buttonRawN,  // raw button level, low when pressed
  button_if.source btn          // cleaned level
);
  logic syncA;
  logic syncB;
  logic prevB;
  logic [31:0] settleCnt;
  logic level;
  logic valid;
  wire stableEnd = (settleCnt == 32'(SETTLE_CYCLES - 1));

  // Released is the idle level; a floating pin reads high
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      syncA <= 1'b1;
      syncB <= 1'b1;
      prevB <= 1'b1;
    end else begin
      syncA <= buttonRawN;
      syncB <= syncA;
      prevB <= syncB;
    end
  end

  // Any edge restarts the settle time, so bounce never reaches level
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      settleCnt <= 32'h0;
      level <= 1'b1;
      valid <= 1'b0;
    end else if (syncB != prevB) begin
      settleCnt <= 32'h0;
    end else if (stableEnd) begin
      level <= prevB;
      valid <= 1'b1;
    end else begin
      settleCnt <= settleCnt + 32'h1;
    end
  end

  assign btn.level = level;
  assign btn.valid = valid;

  AST_DEBOUNCE_SETTLED: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(level) |-> $past(stableEnd) && $past(syncB) == $past(prevB))
    else $error("Button level changed before settle time");
endmodule

//--- core/status_led_cfg.svh
// Purpose: constants for the status lamp and factory reset supervisor
// Assumes: 125 MHz system clock
// Notes: times are in milliseconds; cycle counts are derived in the top
`ifndef STATUS_LED_CFG_SVH
`define STATUS_LED_CFG_SVH

`define CLK_FREQ_MHZ 125
`define CYC_PER_MS (`CLK_FREQ_MHZ * 1000)

`define ARM_TIME_MS 5000
`define ABANDON_TIME_MS 10000
`define DEBOUNCE_TIME_MS 20
`define FAST_HALF_MS 100
`define SLOW_HALF_MS 500
`define PASSIVE_HALF_MS 250
`define BUSOFF_HALF_MS 750
`define WINDOW_HALF_MS 125
`define FLASH_TIME_MS 50

`define BLK_FAST 0
`define BLK_SLOW 1
`define BLK_PASSIVE 2
`define BLK_BUSOFF 3
`define BLK_WINDOW 4
`define BLK_NUM 5

`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define IRQ_STATUS_OFS 12'h008
`define IRQ_CLEAR_OFS 12'h00C
`define IRQ_ENABLE_OFS 12'h010

`define CTRL_CAN_EN_BIT 0
`define CTRL_NET_LSB 1
`define CTRL_NET_MSB 2
`define CTRL_RESET 3'h1

`define IRQ_W 4
`define IRQ_ERR_FRAME 0
`define IRQ_BUS_OFF 1
`define IRQ_ARMED 2
`define IRQ_ABANDON 3
`define IRQ_ENABLE_RESET 4'h0

`endif

//--- core/status_led_factory_reset.sv
// Purpose: status lamps and power-up factory reset supervisor, APB slave
// Assumes: CAN state inputs and error frame pulse synchronous to clk_sys
// Notes: timing counts are parameters so a simulation can shorten them
// Overview of operation
// - Power lamp steadily lit while running
// - Network lamp fast blink awaiting address lease
// - Network lamp slow blink when ready
// - Network lamp steady while host connected
// - Error lamp: passive blink, bus-off slower, frame flash
// - CAN lamp blinks on passive/bus-off, not frames
// - Held at boot: CAN and error lamps steady
// - After 5 s held, those lamps flash
// - Release while flashing restores defaults and reboots
// - Still held at 10 s: continue normally
// - On abandon, stop flashing CAN and error lamps
//
// Our own choices: the register addresses and the APB interface to the registers.
`include "status_led_cfg.svh"
module status_led_factory_reset
  import status_led_pkg::*;
#(
  parameter int unsigned ARM_CYCLES = `ARM_TIME_MS * `CYC_PER_MS,
  // Scaled from the arm time so one override keeps the ratio
  parameter int unsigned ABANDON_CYCLES = 32'(64'(ARM_CYCLES) * `ABANDON_TIME_MS / `ARM_TIME_MS),
  parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_TIME_MS * `CYC_PER_MS,
  parameter int unsigned FAST_HALF_CYCLES = `FAST_HALF_MS * `CYC_PER_MS,
  parameter int unsigned SLOW_HALF_CYCLES =
    32'(64'(FAST_HALF_CYCLES) * `SLOW_HALF_MS / `FAST_HALF_MS),
  parameter int unsigned PASSIVE_HALF_CYCLES =
    32'(64'(FAST_HALF_CYCLES) * `PASSIVE_HALF_MS / `FAST_HALF_MS),
  parameter int unsigned BUSOFF_HALF_CYCLES =
    32'(64'(FAST_HALF_CYCLES) * `BUSOFF_HALF_MS / `FAST_HALF_MS),
  parameter int unsigned WINDOW_HALF_CYCLES = `WINDOW_HALF_MS * `CYC_PER_MS,
  parameter int unsigned FLASH_CYCLES = `FLASH_TIME_MS * `CYC_PER_MS
) (
  input wire logic clk_sys,         // system clock, 125 MHz
  input wire logic reset_n,         // synchronous reset, active low
  input wire logic psel,            // APB select
  input wire logic penable,         // APB enable
  input wire logic pwrite,          // APB direction, high for write
  input wire logic [11:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,   // APB write data
  output logic [31:0] prdata,       // APB read data
  output logic pready,              // APB ready
  output logic pslverr,             // APB error on unmapped address
  input wire logic resetButtonN,    // factory reset pin, low while pressed
  input wire logic errorPassive,    // CAN controller in error passive
  input wire logic busOff,          // CAN controller bus off
  input wire logic errorFrame,      // one-cycle pulse per error frame seen
  output logic powerLamp,           // power lamp, high = lit
  output logic canLamp,             // CAN status lamp
  output logic errorLamp,           // error lamp
  output logic networkLamp,         // network lamp
  output logic configRestore,       // one-cycle pulse: load factory defaults
  output logic rebootReq,           // level: reboot the unit
  output logic irq                  // level interrupt
);
  import status_led_pkg::*;

  button_if btnBus ();

  reset_debounce #(.SETTLE_CYCLES(DEBOUNCE_CYCLES)) uDebounce (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .buttonRawN(resetButtonN),
    .btn(btnBus.source)
  );

  // Blink phase generators, all free running so lamps stay in step
  localparam logic [31:0] HALF [`BLK_NUM] = '{32'(FAST_HALF_CYCLES),
    32'(SLOW_HALF_CYCLES), 32'(PASSIVE_HALF_CYCLES), 32'(BUSOFF_HALF_CYCLES),
    32'(WINDOW_HALF_CYCLES)};
  wire [`BLK_NUM-1:0] blinkPhase;

  for (genvar i = 0; i < `BLK_NUM; i++) begin : g_blink
    logic [31:0] cnt;
    logic ph;
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        cnt <= 32'h0;
        ph <= 1'b0;
      end else if (cnt == HALF[i] - 32'h1) begin
        cnt <= 32'h0;
        ph <= ~ph;
      end else begin
        cnt <= cnt + 32'h1;
      end
    end
    assign blinkPhase[i] = ph;
  end

  // Bus-off wins over error passive; both lamps share the pattern
  function automatic logic faultBlink(input logic boff, input logic [`BLK_NUM-1:0] p);
    faultBlink = boff ? p[`BLK_BUSOFF] : p[`BLK_PASSIVE];
  endfunction

  // Registers
  logic [2:0] ctrl;
  logic [`IRQ_W-1:0] irqStatus;
  logic [`IRQ_W-1:0] irqEnable;
  phase_t phase;
  phase_t next_phase;
  logic [31:0] bootCount;
  logic [31:0] flashCnt;
  logic busOffPrev;

  wire canEnable = ctrl[`CTRL_CAN_EN_BIT];
  wire net_state_t netState = net_state_t'(ctrl[`CTRL_NET_MSB:`CTRL_NET_LSB]);
  wire btnHigh = btnBus.level;
  wire armPoint = (bootCount >= 32'(ARM_CYCLES - 1));
  wire abandonPoint = (bootCount >= 32'(ABANDON_CYCLES - 1));
  wire faulted = errorPassive | busOff;
  wire flashOn = (flashCnt != 32'h0);
  wire inNormal = (phase == PH_NORMAL);

  // Time since boot, saturating once the reset window has closed
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bootCount <= 32'h0;
    end else if (!abandonPoint) begin
      bootCount <= bootCount + 32'h1;
    end
  end

  // Boot phase: the button level is caught only after the debouncer settles
  always_comb begin
    next_phase = phase;
    unique case (phase)
      PH_PROBE: begin
        if (btnBus.valid) begin
          next_phase = btnHigh ? PH_NORMAL : PH_HELD;
        end
      end
      PH_HELD: begin
        if (btnHigh) begin
          next_phase = PH_NORMAL;
        end else if (armPoint) begin
          next_phase = PH_ARMED;
        end
      end
      PH_ARMED: begin
        if (btnHigh) begin
          next_phase = PH_REBOOT;
        end else if (abandonPoint) begin
          next_phase = PH_NORMAL;
        end
      end
      PH_REBOOT: next_phase = PH_REBOOT;
      PH_NORMAL: next_phase = PH_NORMAL;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phase <= PH_PROBE;
    end else begin
      phase <= next_phase;
    end
  end

  // Error frame flash; frames closer than the flash time merge into one
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flashCnt <= 32'h0;
    end else if (errorFrame && inNormal) begin
      flashCnt <= 32'(FLASH_CYCLES);
    end else if (flashOn) begin
      flashCnt <= flashCnt - 32'h1;
    end
  end

  // Lamp selection
  wire heldSteady = (phase == PH_HELD);
  wire windowFlash = (phase == PH_ARMED) & blinkPhase[`BLK_WINDOW];
  wire faultLamp = faultBlink(busOff, blinkPhase);
  wire next_canLamp = heldSteady | windowFlash |
    (inNormal & (faulted ? faultLamp : canEnable));
  wire next_errorLamp = heldSteady | windowFlash |
    (inNormal & (faulted ? faultLamp : flashOn));
  wire next_networkLamp = (phase != PH_REBOOT) &
    ((netState == NET_WAIT) ? blinkPhase[`BLK_FAST] :
     (netState == NET_READY) ? blinkPhase[`BLK_SLOW] :
     (netState == NET_CONNECTED));
  wire leaving = (phase == PH_ARMED) & (next_phase == PH_REBOOT);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      powerLamp <= 1'b1;
      canLamp <= 1'b0;
      errorLamp <= 1'b0;
      networkLamp <= 1'b0;
      configRestore <= 1'b0;
      rebootReq <= 1'b0;
    end else begin
      powerLamp <= 1'b1;
      canLamp <= next_canLamp;
      errorLamp <= next_errorLamp;
      networkLamp <= next_networkLamp;
      configRestore <= leaving;
      rebootReq <= (next_phase == PH_REBOOT);
    end
  end

  // Interrupt events
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busOffPrev <= 1'b0;
    end else begin
      busOffPrev <= busOff;
    end
  end

  wire [`IRQ_W-1:0] irqEvents;
  assign irqEvents[`IRQ_ERR_FRAME] = errorFrame & inNormal;
  assign irqEvents[`IRQ_BUS_OFF] = busOff & ~busOffPrev;
  assign irqEvents[`IRQ_ARMED] = (phase == PH_HELD) & (next_phase == PH_ARMED);
  assign irqEvents[`IRQ_ABANDON] = (phase == PH_ARMED) & (next_phase == PH_NORMAL);

  // APB: one wait state; writes land on the edge that completes the access
  wire apbAccess = psel & penable;
  wire apbDone = apbAccess & pready;
  wire apbWrite = apbDone & pwrite;
  wire hitCtrl = (paddr == `CTRL_OFS);
  wire hitStatus = (paddr == `STATUS_OFS);
  wire hitIrqStatus = (paddr == `IRQ_STATUS_OFS);
  wire hitIrqClear = (paddr == `IRQ_CLEAR_OFS);
  wire hitIrqEnable = (paddr == `IRQ_ENABLE_OFS);
  wire mapped = hitCtrl | hitStatus | hitIrqStatus | hitIrqClear | hitIrqEnable;
  wire [`IRQ_W-1:0] irqClear = (apbWrite && hitIrqClear) ? pwdata[`IRQ_W-1:0] : '0;
  // A new event in the clearing cycle survives the clear
  wire [`IRQ_W-1:0] next_irqStatus = (irqStatus & ~irqClear) | irqEvents;
  wire [`IRQ_W-1:0] next_irqEnable = (apbWrite && hitIrqEnable) ?
    pwdata[`IRQ_W-1:0] : irqEnable;
  wire [31:0] statusWord = {22'h0, busOff, errorPassive, btnHigh, phase,
    networkLamp, errorLamp, canLamp, powerLamp};
  wire [31:0] readMux = hitCtrl ? {29'h0, ctrl} :
    hitStatus ? statusWord :
    hitIrqStatus ? {28'h0, irqStatus} :
    hitIrqEnable ? {28'h0, irqEnable} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apbAccess & ~pready;
      pslverr <= apbAccess & ~pready & ~mapped;
      prdata <= (apbAccess && !pready && !pwrite) ? readMux : 32'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl <= `CTRL_RESET;
      irqStatus <= '0;
      irqEnable <= `IRQ_ENABLE_RESET;
      irq <= 1'b0;
    end else begin
      if (apbWrite && hitCtrl) begin
        ctrl <= pwdata[2:0];
      end
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
      irq <= |(next_irqStatus & next_irqEnable);
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_arm_release;
    phase == PH_ARMED && btnHigh;
  endsequence
  sequence s_restore_out;
    configRestore && rebootReq ##1 !configRestore && rebootReq;
  endsequence
  sequence s_frame_quiet;
    errorFrame && inNormal && !faulted;
  endsequence

  AST_POWER_STEADY: assert property ($past(reset_n) |-> powerLamp)
    else $error("Power lamp dark while running");
  AST_NET_FAST: assert property (phase != PH_REBOOT && netState == NET_WAIT
    |=> networkLamp == $past(blinkPhase[`BLK_FAST]))
    else $error("Network lamp not on fast blink");
  AST_NET_SLOW: assert property (phase != PH_REBOOT && netState == NET_READY
    |=> networkLamp == $past(blinkPhase[`BLK_SLOW]))
    else $error("Network lamp not on slow blink");
  AST_NET_STEADY: assert property (phase != PH_REBOOT && netState == NET_CONNECTED
    [*2] |-> networkLamp)
    else $error("Network lamp not steady while connected");
  AST_ERR_FLASH: assert property (s_frame_quiet ##1 !faulted && inNormal
    |=> errorLamp)
    else $error("Error frame gave no flash");
  AST_CAN_FAULT: assert property (inNormal && faulted
    |=> canLamp == errorLamp && canLamp == $past(faultLamp))
    else $error("CAN lamp not blinking with error lamp");
  AST_CAN_FRAME: assert property (s_frame_quiet ##1 inNormal && !faulted
    |=> canLamp == $past(canEnable))
    else $error("Error frame changed CAN lamp");
  AST_HELD_STEADY: assert property (phase == PH_HELD |=> canLamp && errorLamp)
    else $error("Lamps not steady while held");
  AST_ARM_AT_TIME: assert property (phase == PH_HELD && !btnHigh && armPoint
    |=> phase == PH_ARMED ##1 canLamp == $past(blinkPhase[`BLK_WINDOW]))
    else $error("Release window not entered at arm time");
  AST_RESTORE: assert property (s_arm_release |=> s_restore_out)
    else $error("Release in window did not restore and reboot");
  AST_ABANDON: assert property (phase == PH_ARMED && !btnHigh && abandonPoint
    |=> inNormal && !rebootReq ##1 !configRestore && !rebootReq)
    else $error("Timeout did not abandon reset");
  AST_ABANDON_DARK: assert property (inNormal && !faulted && !flashOn
    |=> !errorLamp)
    else $error("Error lamp still flashing after abandon");
  AST_EARLY_RELEASE: assert property (phase == PH_HELD && btnHigh
    |=> inNormal ##1 !configRestore && !rebootReq)
    else $error("Early release did not boot normally");
endmodule

//--- core/status_led_pkg.sv
// Purpose: types shared by the lamp supervisor files
// Assumes: nothing
// Notes: enum codes follow declaration order, counting up from 0
package status_led_pkg;
  typedef enum logic [1:0] {NET_WAIT, NET_READY, NET_CONNECTED, NET_OFF} net_state_t;
  typedef enum logic [2:0] {PH_PROBE, PH_HELD, PH_ARMED, PH_REBOOT, PH_NORMAL} phase_t;
endpackage

//--- dv/button_model.sv
// Purpose: push-button that grounds the factory reset pin while pressed
// Assumes: press is driven by the bench at rising edges
// Notes: contacts bounce for a few cycles after every change of press
module button_model #(
  parameter int BOUNCE = 3
) (
  input wire logic clk_sys, // system clock
  input wire logic press,   // operator holds the button
  output logic pinN         // reset pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  logic pin = 1'b1;
  int left = 0;
  assign pinN = pin;
  always @(posedge clk_sys) begin
    if (press !== last) begin
      last <= press;
      left <= BOUNCE;
      pin <= ~pin;
    end else if (left > 0) begin
      left <= left - 1;
      pin <= ~pin;
    end else begin
      // Released leaves the pin open: the pull-up gives high
      pin <= press ? 1'b0 : 1'b1;
    end
  end
endmodule

//--- dv/testbench.sv
// Purpose: self-checking bench for the lamp and factory reset supervisor
// Assumes: small timing parameters, APB master in the bench
// Notes: random values come from a 16-bit LFSR
`include "status_led_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FAST = 4;
  localparam int SLOW = FAST * `SLOW_HALF_MS / `FAST_HALF_MS;
  localparam int PASSIVE = FAST * `PASSIVE_HALF_MS / `FAST_HALF_MS;
  localparam int BUSOFF = FAST * `BUSOFF_HALF_MS / `FAST_HALF_MS;
  logic clk_sys = 1'b0, reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, ev, resetButtonN;
  logic errorPassive = 1'b0, busOff = 1'b0, errorFrame = 1'b0, press = 1'b0;
  logic powerLamp, canLamp, errorLamp, networkLamp, configRestore, rebootReq, irq;
  logic [15:0] lfsr = 16'h502B;
  logic [1:0] s;
  logic c;
  int fails = 0, testsRun = 0, restoreCount = 0, bootCyc = 0, n;
  always #4 clk_sys = ~clk_sys;
  button_model bm (.clk_sys(clk_sys), .press(press), .pinN(resetButtonN));
  status_led_factory_reset #(.ARM_CYCLES(400), .DEBOUNCE_CYCLES(8),
    .FAST_HALF_CYCLES(FAST), .WINDOW_HALF_CYCLES(6), .FLASH_CYCLES(5)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .resetButtonN(resetButtonN),
    .errorPassive(errorPassive), .busOff(busOff), .errorFrame(errorFrame),
    .powerLamp(powerLamp), .canLamp(canLamp), .errorLamp(errorLamp),
    .networkLamp(networkLamp), .configRestore(configRestore),
    .rebootReq(rebootReq), .irq(irq));
  always @(posedge clk_sys) begin
    bootCyc <= reset_n ? bootCyc + 1 : 0;
    if (configRestore === 1'b1) restoreCount <= restoreCount + 1;
  end
  task print_verdict;
    $display("tests_run=%0d fails=%0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Waits for pready; only the watchdog ends this wait if pready never comes
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Power stays off until the contacts have settled, as an operator would do
  task boot(input logic held);
    reset_n <= 1'b0;
    press <= held;
    cyc(held ? 8 : 2);
    reset_n <= 1'b1;
  endtask
  task upto(input int t);
    while (bootCyc < t) @(posedge clk_sys);
  endtask
  function automatic logic lampv(input int w);
    case (w)
      0: return canLamp;
      1: return errorLamp;
      default: return networkLamp;
    endcase
  endfunction
  // Length of one lamp run after the next toggle; 0 when steady
  task halfp(input int w, output int r);
    logic p;
    int k;
    r = 0;
    k = 0;
    p = lampv(w);
    while (lampv(w) === p && k < 60) begin @(posedge clk_sys); k++; end
    if (k < 60) begin
      p = lampv(w);
      while (lampv(w) === p && r < 60) begin @(posedge clk_sys); r++; end
    end
  endtask
  // First run after a mode change may be partial, so skip it
  task blink(input int w, output int r);
    halfp(w, r);
    halfp(w, r);
  endtask
  function automatic int exp_net(input logic [1:0] st);
    return st == 2'h0 ? FAST : (st == 2'h1 ? SLOW : 0);
  endfunction
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  initial begin
    cyc(20000);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict;
  end
  initial begin
    boot(1'b0);
    upto(30);
    chk(powerLamp, 1, "power lamp");
    apb(0, `CTRL_OFS, 0); chk(rdv, 32'h1, "ctrl reset");
    apb(0, `IRQ_ENABLE_OFS, 0); chk(rdv, 32'h0, "irq enable reset");
    apb(0, 12'h020, 0); chk({rdv[30:0], ev}, 32'h1, "unmapped");
    for (int i = 0; i < 8; i++) begin
      s = i < 4 ? i[1:0] : lfsr[1:0];
      c = lfsr[2];
      lfsr = lfsr_next(lfsr);
      apb(1, `CTRL_OFS, {29'h0, s, c});
      blink(2, n);
      chk(n, exp_net(s), "network blink");
      if (s[1]) chk(networkLamp, s == 2'h2, "network steady");
      chk(canLamp, c, "can lamp idle");
    end
    apb(1, `CTRL_OFS, 32'h1);
    errorPassive <= 1'b1;
    blink(1, n); chk(n, PASSIVE, "passive err");
    blink(0, n); chk(n, PASSIVE, "passive can");
    busOff <= 1'b1;
    blink(1, n); chk(n, BUSOFF, "busoff err");
    blink(0, n); chk(n, BUSOFF, "busoff can");
    errorPassive <= 1'b0;
    busOff <= 1'b0;
    apb(1, `IRQ_ENABLE_OFS, 32'h1);
    cyc(30);
    errorFrame <= 1'b1;
    cyc(1);
    errorFrame <= 1'b0;
    halfp(1, n); chk(n, 5, "frame flash");
    chk(canLamp, 1, "can lamp on frame");
    chk(irq, 1, "irq raised");
    apb(0, `IRQ_STATUS_OFS, 0); chk(rdv, 32'h3, "irq status");
    apb(1, `IRQ_ENABLE_OFS, 0);
    cyc(2); chk(irq, 0, "irq masked");
    apb(1, `IRQ_CLEAR_OFS, 32'hF);
    apb(0, `IRQ_STATUS_OFS, 0); chk(rdv, 32'h0, "irq cleared");
    s = lfsr[1:0];
    apb(1, `IRQ_ENABLE_OFS, {28'h0, lfsr[5:2]});
    apb(0, `IRQ_ENABLE_OFS, 0); chk(rdv, {28'h0, lfsr[5:2]}, "irq enable rw");
    boot(1'b1);
    upto(30);
    chk({canLamp, errorLamp}, 2'h3, "held steady");
    press <= 1'b0;
    cyc(4);
    press <= 1'b1;
    upto(300);
    halfp(0, n); chk(n, 0, "glitch ignored");
    upto(410);
    blink(0, n); chk(n, 6, "window can");
    blink(1, n); chk(n, 6, "window err");
    press <= 1'b0;
    n = 0;
    while (restoreCount == 0 && n < 40) begin cyc(1); n++; end
    cyc(3);
    chk(restoreCount, 1, "restore pulse");
    chk({configRestore, rebootReq}, 2'h1, "reboot held");
    boot(1'b1);
    upto(830);
    halfp(0, n); chk(n, 0, "can stops");
    halfp(1, n); chk({n[30:0], errorLamp}, 0, "err stops");
    apb(0, `IRQ_STATUS_OFS, 0); chk(rdv, 32'hC, "armed and abandon");
    press <= 1'b0;
    cyc(40);
    chk({restoreCount[30:0], rebootReq}, 2, "no reboot");
    boot(1'b1);
    upto(100);
    press <= 1'b0;
    upto(900);
    chk({restoreCount[30:0], rebootReq}, 2, "early release");
    apb(0, `STATUS_OFS, 0); chk(rdv[7:4], 4'hC, "normal phase");
    chk(powerLamp, 1, "power lamp");
    print_verdict;
  end
endmodule
